// ===== logic/pod_pkg.sv
// Constants, types and decode for the peripheral output dispatcher
// Notes on behaviour
// - Code 00 sends tape output in whole blocks of 512 locations.
// - Code 09 sends all new data to tape; refused in manual dump.
// - Codes 1x/2x/3x: addressed printer, printable, comma-delimited or binary.
// - Codes 4x/5x/6x: pin-enabled printer, printable, comma-delimited or binary.
// - Code 7N targets storage module N, also for writing a file mark.
// - Code 80 copies new data to the other area; on-line only.
// - Code 81 copies the whole active area to the other; on-line only.
// - Source is the active area; it returns to area 1 at table start.
// - A request arriving while the port is busy is queued, no stall.
// - When the port frees, queued requests are served one at a time.
// - A request equal to a queued entry is rejected.
// - Served entry sends from its pointer to storage pointer latched at start.
// - Tape writes always fill 512 locations, padding with nulls.
// - Code 09 writes everything up to the storage pointer, short block too.
// - Pin-enabled printers use the sync device enable line as enable.
// - Module address 1 finds the lowest connected module.
// - Absent module: pointer kept, request dropped.
// - Manual dump skips area step when area 2 has no memory.
// - Manual start defaults to device pointer, end to storage pointer.
// - Manual dump shows step 04 and a location that stops when done.
// - A key aborts manual dump after the current block.
// - Module data is sent only after the module is seen present.
package pod_pkg;
  localparam int PTR_W = 16;
  localparam int CODE_W = 8;
  localparam int ENT_W = CODE_W + 2;
  localparam int QDEPTH = 8;
  localparam int BLOCK_LEN = 512;
  localparam int BLK_W = 9;
  localparam logic [3:0] HI_TAPE = 4'h0;
  localparam logic [3:0] LO_TAPE_BLK = 4'h0;
  localparam logic [3:0] LO_TAPE_ALL = 4'h9;
  localparam logic [3:0] HI_APRN_TXT = 4'h1;
  localparam logic [3:0] HI_APRN_BIN = 4'h3;
  localparam logic [3:0] HI_EPRN_TXT = 4'h4;
  localparam logic [3:0] HI_EPRN_BIN = 4'h6;
  localparam logic [3:0] HI_MOD = 4'h7;
  localparam logic [3:0] HI_COPY = 4'h8;
  localparam logic [3:0] LO_COPY_NEW = 4'h0;
  localparam logic [3:0] LO_COPY_ALL = 4'h1;
  localparam logic [3:0] BAUD_MAX = 4'h3;
  localparam logic [3:0] MOD_UNIVERSAL = 4'h1;
  localparam logic [3:0] MOD_ADDR_MAX = 4'h8;
  localparam logic [7:0] STEP_AREA = 8'h08;
  localparam logic [7:0] STEP_DEV = 8'h01;
  localparam logic [7:0] STEP_START = 8'h02;
  localparam logic [7:0] STEP_END = 8'h03;
  localparam logic [7:0] STEP_DUMP = 8'h04;
  localparam logic [7:0] MAN_CODE_DEF = 8'h00;
  localparam logic [1:0] AREA_KEY_2 = 2'h2;
  localparam int CLK_MHZ = 50;
  localparam int PROBE_TIME_NS = 2000;
  localparam int PROBE_CYC = (PROBE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int PROBE_W = $clog2(PROBE_CYC + 1);

  typedef enum logic [2:0] {
    C_TAPE_BLK, C_TAPE_ALL, C_APRN, C_EPRN, C_MOD, C_COPY_NEW, C_COPY_ALL, C_BAD
  } pod_class_type;

  function automatic pod_class_type pod_class(input logic [CODE_W-1:0] code);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = code[7:4];
    lo = code[3:0];
    if (hi == HI_TAPE && lo == LO_TAPE_BLK) return C_TAPE_BLK;
    else if (hi == HI_TAPE && lo == LO_TAPE_ALL) return C_TAPE_ALL;
    else if (hi >= HI_APRN_TXT && hi <= HI_APRN_BIN && lo <= BAUD_MAX) return C_APRN;
    else if (hi >= HI_EPRN_TXT && hi <= HI_EPRN_BIN && lo <= BAUD_MAX) return C_EPRN;
    else if (hi == HI_MOD && lo >= MOD_UNIVERSAL && lo <= MOD_ADDR_MAX) return C_MOD;
    else if (hi == HI_COPY && lo == LO_COPY_NEW) return C_COPY_NEW;
    else if (hi == HI_COPY && lo == LO_COPY_ALL) return C_COPY_ALL;
    else return C_BAD;
  endfunction
endpackage

// ===== logic/pod_queue.sv
// Shift-style request queue with duplicate detection
`timescale 1ns/1ps
module pod_queue #(
  parameter int W = pod_pkg::ENT_W,
  parameter int DEPTH = pod_pkg::QDEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Fill side
  input wire logic push,
  input wire logic [W-1:0] push_data,
  output logic full,
  output logic dup,
  // Drain side
  input wire logic pop,
  output logic [W-1:0] head,
  output logic empty
);
  localparam int CNT_W = $clog2(DEPTH + 1);
  logic [W-1:0] entry_ff [DEPTH];
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] wr_idx;
  logic do_push;
  logic do_pop;

  assign empty = (cnt_ff == '0);
  assign full = (cnt_ff == CNT_W'(DEPTH));
  assign do_pop = pop && !empty;
  assign do_push = push && (!full || do_pop);
  assign wr_idx = do_pop ? cnt_ff - CNT_W'(1) : cnt_ff;
  assign head = entry_ff[0];

  always_comb begin
    dup = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (CNT_W'(i) < cnt_ff && entry_ff[i] == push_data) dup = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
    end else if (do_push && !do_pop) begin
      cnt_ff <= cnt_ff + CNT_W'(1);
    end else if (do_pop && !do_push) begin
      cnt_ff <= cnt_ff - CNT_W'(1);
    end
  end

  // Oldest entry always sits at slot 0
  for (genvar g = 0; g < DEPTH; g++) begin : g_slot
    always_ff @(posedge ref_clk) begin
      if (do_push && wr_idx == CNT_W'(g)) begin
        entry_ff[g] <= push_data;
      end else if (do_pop) begin
        if (g < DEPTH - 1) entry_ff[g] <= entry_ff[(g < DEPTH - 1) ? g + 1 : g];
      end
    end
  end
endmodule

// ===== logic/pod_dispatch.sv
// Peripheral output dispatcher: request queue, transfer engine, manual dump
`timescale 1ns/1ps
module pod_dispatch #(
  parameter int PTR_W = pod_pkg::PTR_W,
  parameter int QDEPTH = pod_pkg::QDEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Program table side
  input wire logic table_start,
  input wire logic area_sel_valid,
  input wire logic area_sel,
  input wire logic req_valid,
  input wire logic [7:0] req_code,
  input wire logic req_mark,
  output logic req_taken_ff,
  output logic req_dup_ff,
  // Storage state
  input wire logic [PTR_W-1:0] dsp,
  input wire logic area2_alloc,
  // Peripheral port
  input wire logic port_busy,
  input wire logic module_present,
  input wire logic xfer_ready,
  output logic port_claim_ff,
  output logic sync_device_enable_line_ff,
  output logic [3:0] module_addr_ff,
  output logic xfer_valid_ff,
  output logic [PTR_W-1:0] xfer_addr_ff,
  output logic xfer_null_ff,
  output logic xfer_mark_ff,
  output logic xfer_area_ff,
  output logic xfer_to_other_ff,
  output pod_pkg::pod_class_type dev_class_ff,
  output logic [1:0] fmt_ff,
  output logic [1:0] baud_ff,
  // Manual dump keyboard and display
  input wire logic man_begin,
  input wire logic man_enter,
  input wire logic man_keyed,
  input wire logic [PTR_W-1:0] man_value,
  input wire logic man_key,
  output logic [7:0] disp_id_ff,
  output logic [PTR_W-1:0] disp_data_ff
);
  typedef enum logic [2:0] {E_IDLE, E_PROBE, E_SEND, E_PAD, E_MARK, E_DONE} pod_eng_type;
  typedef enum logic [2:0] {M_OFF, M_AREA, M_DEV, M_START, M_END, M_READY, M_DUMP} pod_man_type;
  localparam logic [PTR_W-1:0] BLK_MASK = ~(PTR_W'(pod_pkg::BLOCK_LEN - 1));
  localparam logic [PTR_W-1:0] AREA_BASE = '0;

  pod_eng_type st_ff;
  pod_man_type man_st_ff;
  logic act_area_ff;
  logic [PTR_W-1:0] tape_out_pointer_ff;
  logic [PTR_W-1:0] module_out_pointer_ff;
  logic [PTR_W-1:0] printer_out_pointer_ff;
  logic [PTR_W-1:0] copy_out_pointer_ff;
  logic [PTR_W-1:0] cur_ptr_ff;
  logic [PTR_W-1:0] end_ptr_ff;
  logic [pod_pkg::BLK_W-1:0] blk_cnt_ff;
  logic [pod_pkg::PROBE_W-1:0] probe_cnt_ff;
  logic manual_ff, mark_ff, pad_ff, univ_ff, absent_ff, probed_ok_ff;
  logic present_meta_ff, present_ff;
  logic man_pend_ff, abort_ff, man_area_ff;
  logic [7:0] man_code_ff;
  logic [PTR_W-1:0] man_start_ff, man_end_ff;
  logic [pod_pkg::ENT_W-1:0] push_data, q_head;
  logic q_full, q_dup, q_empty, q_push, q_pop;
  pod_pkg::pod_class_type req_cls, ld_cls, man_cls;
  logic ld_go, ld_man, ld_area, ld_mark;
  logic [7:0] ld_code;
  logic [PTR_W-1:0] ld_start, ld_end;
  logic xfer_free;

  function automatic logic [PTR_W-1:0] ptr_for(input pod_pkg::pod_class_type c,
      input logic [PTR_W-1:0] tp, input logic [PTR_W-1:0] mp,
      input logic [PTR_W-1:0] pp, input logic [PTR_W-1:0] cp);
    case (c)
      pod_pkg::C_TAPE_BLK, pod_pkg::C_TAPE_ALL: return tp;
      pod_pkg::C_MOD: return mp;
      pod_pkg::C_APRN, pod_pkg::C_EPRN: return pp;
      pod_pkg::C_COPY_NEW: return cp;
      default: return AREA_BASE;
    endcase
  endfunction

  // Presence pin crossing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      present_meta_ff <= 1'b0;
      present_ff <= 1'b0;
    end else begin
      present_meta_ff <= module_present;
      present_ff <= present_meta_ff;
    end
  end

  // Active area; a select in the same cycle as table start wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) act_area_ff <= 1'b0;
    else if (area_sel_valid) act_area_ff <= area_sel;
    else if (table_start) act_area_ff <= 1'b0;
  end

  // Request intake never stalls the program
  assign req_cls = pod_pkg::pod_class(req_code);
  assign push_data = {req_mark && req_cls == pod_pkg::C_MOD, act_area_ff, req_code};
  assign q_push = req_valid && req_cls != pod_pkg::C_BAD && !q_dup;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_taken_ff <= 1'b0;
      req_dup_ff <= 1'b0;
    end else begin
      req_taken_ff <= q_push && (!q_full || q_pop);
      req_dup_ff <= req_valid && q_dup;
    end
  end

  pod_queue #(.W(pod_pkg::ENT_W), .DEPTH(QDEPTH)) u_queue (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .push(q_push),
    .push_data(push_data),
    .full(q_full),
    .dup(q_dup),
    .pop(q_pop),
    .head(q_head),
    .empty(q_empty)
  );

  // Load selection: a pending manual dump goes ahead of the queue
  always_comb begin
    ld_man = man_pend_ff;
    ld_code = ld_man ? man_code_ff : q_head[pod_pkg::CODE_W-1:0];
    ld_area = ld_man ? man_area_ff : q_head[pod_pkg::CODE_W];
    ld_mark = ld_man ? 1'b0 : q_head[pod_pkg::CODE_W+1];
    ld_cls = pod_pkg::pod_class(ld_code);
    ld_start = ptr_for(ld_cls, tape_out_pointer_ff, module_out_pointer_ff,
                       printer_out_pointer_ff, copy_out_pointer_ff);
    ld_end = dsp;
    if (ld_man) begin
      ld_start = man_start_ff;
      ld_end = man_end_ff;
    end else if (ld_cls == pod_pkg::C_TAPE_BLK) begin
      ld_end = ld_start + ((dsp - ld_start) & BLK_MASK);
    end
    ld_go = st_ff == E_IDLE && !port_busy && (ld_man || !q_empty);
  end
  assign q_pop = ld_go && !ld_man;
  assign xfer_free = !xfer_valid_ff || xfer_ready;

  // Transfer engine
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= E_IDLE;
      cur_ptr_ff <= '0;
      end_ptr_ff <= '0;
      blk_cnt_ff <= '0;
      probe_cnt_ff <= '0;
      manual_ff <= 1'b0;
      mark_ff <= 1'b0;
      pad_ff <= 1'b0;
      univ_ff <= 1'b0;
      absent_ff <= 1'b0;
      probed_ok_ff <= 1'b0;
      module_addr_ff <= '0;
      dev_class_ff <= pod_pkg::C_BAD;
      fmt_ff <= '0;
      baud_ff <= '0;
      xfer_area_ff <= 1'b0;
      xfer_to_other_ff <= 1'b0;
      xfer_valid_ff <= 1'b0;
      xfer_addr_ff <= '0;
      xfer_null_ff <= 1'b0;
      xfer_mark_ff <= 1'b0;
    end else begin
      case (st_ff)
        E_IDLE: begin
          if (ld_go) begin
            manual_ff <= ld_man;
            mark_ff <= ld_mark;
            cur_ptr_ff <= ld_start;
            end_ptr_ff <= ld_end;
            blk_cnt_ff <= '0;
            probe_cnt_ff <= '0;
            absent_ff <= 1'b0;
            probed_ok_ff <= 1'b0;
            dev_class_ff <= ld_cls;
            xfer_area_ff <= ld_area;
            xfer_to_other_ff <= ld_cls == pod_pkg::C_COPY_NEW ||
                                ld_cls == pod_pkg::C_COPY_ALL;
            pad_ff <= ld_cls == pod_pkg::C_TAPE_ALL ||
                      (ld_man && ld_cls == pod_pkg::C_TAPE_BLK);
            baud_ff <= ld_code[1:0];
            fmt_ff <= (ld_cls == pod_pkg::C_EPRN) ?
                      2'(ld_code[7:4] - pod_pkg::HI_EPRN_TXT) :
                      2'(ld_code[7:4] - pod_pkg::HI_APRN_TXT);
            module_addr_ff <= ld_code[3:0];
            univ_ff <= ld_code[3:0] == pod_pkg::MOD_UNIVERSAL;
            st_ff <= (ld_cls == pod_pkg::C_MOD) ? E_PROBE : E_SEND;
          end
        end
        E_PROBE: begin
          if (probe_cnt_ff == pod_pkg::PROBE_W'(pod_pkg::PROBE_CYC - 1)) begin
            probe_cnt_ff <= '0;
            if (present_ff) begin
              probed_ok_ff <= 1'b1;
              st_ff <= mark_ff ? E_MARK : E_SEND;
            end else if (univ_ff && module_addr_ff != pod_pkg::MOD_ADDR_MAX) begin
              module_addr_ff <= module_addr_ff + 4'h1;
            end else begin
              absent_ff <= 1'b1;
              st_ff <= E_DONE;
            end
          end else begin
            probe_cnt_ff <= probe_cnt_ff + pod_pkg::PROBE_W'(1);
          end
        end
        E_SEND: begin
          if (xfer_free) begin
            if (cur_ptr_ff != end_ptr_ff && !(abort_ff && manual_ff && blk_cnt_ff == '0)) begin
              xfer_valid_ff <= 1'b1;
              xfer_addr_ff <= cur_ptr_ff;
              xfer_null_ff <= 1'b0;
              cur_ptr_ff <= cur_ptr_ff + PTR_W'(1);
              blk_cnt_ff <= blk_cnt_ff + pod_pkg::BLK_W'(1);
            end else begin
              xfer_valid_ff <= 1'b0;
              st_ff <= (pad_ff && blk_cnt_ff != '0) ? E_PAD : E_DONE;
            end
          end
        end
        E_PAD: begin
          if (xfer_free) begin
            if (blk_cnt_ff != '0) begin
              xfer_valid_ff <= 1'b1;
              xfer_null_ff <= 1'b1;
              blk_cnt_ff <= blk_cnt_ff + pod_pkg::BLK_W'(1);
            end else begin
              xfer_valid_ff <= 1'b0;
              xfer_null_ff <= 1'b0;
              st_ff <= E_DONE;
            end
          end
        end
        E_MARK: begin
          if (xfer_valid_ff && xfer_ready) begin
            xfer_valid_ff <= 1'b0;
            xfer_mark_ff <= 1'b0;
            st_ff <= E_DONE;
          end else if (!xfer_valid_ff) begin
            xfer_valid_ff <= 1'b1;
            xfer_mark_ff <= 1'b1;
          end
        end
        default: st_ff <= E_IDLE;
      endcase
    end
  end

  // Port claim and enable line; the line doubles as printer enable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_claim_ff <= 1'b0;
      sync_device_enable_line_ff <= 1'b0;
    end else begin
      port_claim_ff <= st_ff != E_IDLE || ld_go;
      sync_device_enable_line_ff <= st_ff == E_PROBE ||
          ((st_ff == E_SEND || st_ff == E_PAD) && dev_class_ff == pod_pkg::C_EPRN);
    end
  end

  // Device pointers advance only after a completed on-line transfer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tape_out_pointer_ff <= '0;
      module_out_pointer_ff <= '0;
      printer_out_pointer_ff <= '0;
      copy_out_pointer_ff <= '0;
    end else if (st_ff == E_DONE && !manual_ff && !absent_ff) begin
      case (dev_class_ff)
        pod_pkg::C_TAPE_BLK, pod_pkg::C_TAPE_ALL: tape_out_pointer_ff <= cur_ptr_ff;
        pod_pkg::C_MOD: if (!mark_ff) module_out_pointer_ff <= cur_ptr_ff;
        pod_pkg::C_APRN, pod_pkg::C_EPRN: printer_out_pointer_ff <= cur_ptr_ff;
        default: copy_out_pointer_ff <= cur_ptr_ff;
      endcase
    end
  end

  // Manual dump step sequence
  assign man_cls = pod_pkg::pod_class(man_value[7:0]);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      man_st_ff <= M_OFF;
      man_area_ff <= 1'b0;
      man_code_ff <= pod_pkg::MAN_CODE_DEF;
      man_start_ff <= '0;
      man_end_ff <= '0;
      man_pend_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      case (man_st_ff)
        M_OFF: begin
          abort_ff <= 1'b0;
          if (man_begin) begin
            man_area_ff <= 1'b0;
            man_st_ff <= area2_alloc ? M_AREA : M_DEV;
          end
        end
        M_AREA: if (man_enter) begin
          if (man_keyed) man_area_ff <= man_value[1:0] == pod_pkg::AREA_KEY_2;
          man_st_ff <= M_DEV;
        end
        M_DEV: if (man_enter) begin
          if (!man_keyed || !(man_cls inside {pod_pkg::C_BAD, pod_pkg::C_TAPE_ALL,
              pod_pkg::C_COPY_NEW, pod_pkg::C_COPY_ALL})) begin
            if (man_keyed) man_code_ff <= man_value[7:0];
            man_start_ff <= ptr_for(man_keyed ? man_cls : pod_pkg::pod_class(man_code_ff),
                tape_out_pointer_ff, module_out_pointer_ff,
                printer_out_pointer_ff, copy_out_pointer_ff);
            man_st_ff <= M_START;
          end
        end
        M_START: if (man_enter) begin
          if (man_keyed) man_start_ff <= man_value;
          man_end_ff <= dsp;
          man_st_ff <= M_END;
        end
        M_END: if (man_enter) begin
          if (man_keyed) man_end_ff <= man_value;
          man_st_ff <= M_READY;
        end
        M_READY: if (man_enter && man_keyed) begin
          man_pend_ff <= 1'b1;
          man_st_ff <= M_DUMP;
        end
        default: begin
          if (ld_go && ld_man) man_pend_ff <= 1'b0;
          if (man_key) abort_ff <= 1'b1;
          if (!man_pend_ff && st_ff == E_DONE && manual_ff) man_st_ff <= M_OFF;
        end
      endcase
    end
  end

  // Display holds its last value once the dump ends
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      disp_id_ff <= '0;
      disp_data_ff <= '0;
    end else begin
      case (man_st_ff)
        M_AREA: begin
          disp_id_ff <= pod_pkg::STEP_AREA;
          disp_data_ff <= '0;
        end
        M_DEV: begin
          disp_id_ff <= pod_pkg::STEP_DEV;
          disp_data_ff <= PTR_W'(man_code_ff);
        end
        M_START: begin
          disp_id_ff <= pod_pkg::STEP_START;
          disp_data_ff <= man_start_ff;
        end
        M_END: begin
          disp_id_ff <= pod_pkg::STEP_END;
          disp_data_ff <= man_end_ff;
        end
        M_READY: begin
          disp_id_ff <= pod_pkg::STEP_DUMP;
          disp_data_ff <= '0;
        end
        M_DUMP: begin
          disp_id_ff <= pod_pkg::STEP_DUMP;
          if (manual_ff && st_ff == E_SEND) disp_data_ff <= cur_ptr_ff;
        end
        default: ;
      endcase
    end
  end

  property p_area_revert;
    @(posedge ref_clk) disable iff (!reset_n) table_start && !area_sel_valid |=> !act_area_ff;
  endproperty
  a_area_revert: assert property (p_area_revert) else $error("area not reverted");
  property p_dup;
    @(posedge ref_clk) disable iff (!reset_n) req_valid && q_dup |=> req_dup_ff && !req_taken_ff;
  endproperty
  a_dup: assert property (p_dup) else $error("duplicate accepted");
  property p_busy_wait;
    @(posedge ref_clk) disable iff (!reset_n) st_ff == E_IDLE && port_busy |=> st_ff == E_IDLE;
  endproperty
  a_busy_wait: assert property (p_busy_wait) else $error("started on busy port");
  property p_grant;
    @(posedge ref_clk) disable iff (!reset_n) q_pop |=> st_ff != E_IDLE && port_claim_ff;
  endproperty
  a_grant: assert property (p_grant) else $error("pop without grant");
  property p_present;
    @(posedge ref_clk) disable iff (!reset_n)
      xfer_valid_ff && dev_class_ff == pod_pkg::C_MOD |-> probed_ok_ff;
  endproperty
  a_present: assert property (p_present) else $error("module data before presence");
  property p_pad_full;
    @(posedge ref_clk) disable iff (!reset_n) st_ff == E_DONE && pad_ff |-> blk_cnt_ff == '0;
  endproperty
  a_pad_full: assert property (p_pad_full) else $error("tape block not filled");
  property p_sde;
    @(posedge ref_clk) disable iff (!reset_n)
      st_ff == E_SEND && dev_class_ff == pod_pkg::C_EPRN && xfer_valid_ff
      |-> sync_device_enable_line_ff;
  endproperty
  a_sde: assert property (p_sde) else $error("printer enable low");
  property p_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      st_ff == E_SEND && xfer_valid_ff && !xfer_ready |=> xfer_valid_ff && $stable(xfer_addr_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("transfer dropped");
  property p_abort;
    @(posedge ref_clk) disable iff (!reset_n) st_ff == E_DONE && manual_ff && abort_ff && !pad_ff
      |-> blk_cnt_ff == '0 || cur_ptr_ff == end_ptr_ff;
  endproperty
  a_abort: assert property (p_abort) else $error("abort mid block");
  property p_absent;
    @(posedge ref_clk) disable iff (!reset_n) st_ff == E_DONE && absent_ff
      |=> $stable(module_out_pointer_ff) && st_ff == E_IDLE;
  endproperty
  a_absent: assert property (p_absent) else $error("absent module moved pointer");
  property p_skip_area;
    @(posedge ref_clk) disable iff (!reset_n)
      man_st_ff == M_OFF && man_begin && !area2_alloc |=> man_st_ff == M_DEV;
  endproperty
  a_skip_area: assert property (p_skip_area) else $error("area step not skipped");
endmodule

// ===== bench/pod_periph.sv
// Far-side peripheral model: word sink and module presence
`timescale 1ns/1ps
module pod_periph (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Port from the dispatcher
  input wire logic xfer_valid_ff,
  input wire logic xfer_null_ff,
  input wire logic sync_device_enable_line_ff,
  input wire logic [3:0] module_addr_ff,
  // Scenario controls
  input wire logic [15:0] present_mask,
  input wire logic slow,
  // Answers and tallies
  output logic xfer_ready,
  output logic module_present,
  output int n_word,
  output int n_null
);
  // Pulled low when no module answers the probe
  assign module_present = sync_device_enable_line_ff & present_mask[module_addr_ff];
  // Slow mode drops ready every other cycle to stretch each word
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      xfer_ready <= 1'b0;
    end else begin
      xfer_ready <= slow ? ~xfer_ready : 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      n_word <= 0;
      n_null <= 0;
    end else if (xfer_valid_ff && xfer_ready) begin
      n_word <= n_word + 1;
      n_null <= n_null + int'(xfer_null_ff);
    end
  end
endmodule

// ===== bench/peripheral_output_dispatcher_tb.sv
// Testbench for the peripheral output dispatcher
`timescale 1ns/1ps
module peripheral_output_dispatcher_tb;
  logic ref_clk, reset_n, table_start, area_sel_valid, area_sel, req_valid, req_mark;
  logic req_taken_ff, req_dup_ff, area2_alloc, port_busy, module_present, xfer_ready;
  logic port_claim_ff, sync_device_enable_line_ff, xfer_valid_ff, xfer_null_ff, slow;
  logic xfer_mark_ff, xfer_area_ff, xfer_to_other_ff, man_begin, man_enter, man_keyed, man_key;
  logic [7:0] req_code, disp_id_ff;
  logic [15:0] dsp, xfer_addr_ff, man_value, disp_data_ff, present_mask;
  logic [3:0] module_addr_ff, c_addr;
  logic [1:0] fmt_ff, baud_ff, c_fmt, c_baud;
  logic c_sde, c_area;
  pod_pkg::pod_class_type dev_class_ff, c_cls;
  int n_word, n_null, n_mismatch, tests_run, w0, z0;
  pod_dispatch dut_u (.*);
  pod_periph peer_u (.*);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic req(input logic [7:0] c, input logic tk, input logic dp);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_code <= c;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    @(negedge ref_clk);
    chk(req_taken_ff, tk);
    chk(req_dup_ff, dp);
  endtask
  // Waits until the port has been idle for four cycles; keeps the first word's class and the last word's other fields
  task automatic drain;
    int i;
    int q;
    q = -1;
    c_cls = pod_pkg::C_BAD;
    w0 = n_word;
    z0 = n_null;
    for (i = 0; i < 4000; i++) begin
      @(negedge ref_clk);
      if (xfer_valid_ff) begin
        if (c_cls == pod_pkg::C_BAD) c_cls = dev_class_ff;
        {c_fmt, c_baud, c_sde, c_addr, c_area} = {fmt_ff, baud_ff,
          sync_device_enable_line_ff, module_addr_ff, xfer_area_ff};
      end
      if (port_claim_ff) q = 0;
      else if (q >= 0) q++;
      if (q == 4) return;
    end
    n_mismatch++;
    test_done();
  endtask
  task automatic s_queue;
    @(posedge ref_clk);
    port_busy <= 1'b1;
    req(8'h21, 1'b1, 1'b0);
    req(8'h21, 1'b0, 1'b1);
    chk(port_claim_ff, 1'b0);
    @(posedge ref_clk);
    port_busy <= 1'b0;
    drain();
    chk(c_cls, pod_pkg::C_APRN);
    chk(c_fmt, 2'h1);
    chk(c_baud, 2'h1);
    chk(16'(n_word - w0), 16'h0005);
    chk(xfer_addr_ff, 16'h0004);
  endtask
  task automatic s_fifo;
    @(posedge ref_clk);
    port_busy <= 1'b1;
    slow <= 1'b1;
    dsp <= 16'h0008;
    req(8'h09, 1'b1, 1'b0);
    req(8'h52, 1'b1, 1'b0);
    @(posedge ref_clk);
    port_busy <= 1'b0;
    drain();
    chk(c_cls, pod_pkg::C_TAPE_ALL);
    chk(16'(n_word - w0), 16'h0203);
    chk(16'(n_null - z0), 16'h01F8);
    chk(c_sde, 1'b1);
    chk(c_baud, 2'h2);
  endtask
  task automatic s_module;
    req(8'h73, 1'b1, 1'b0);
    drain();
    chk(16'(n_word - w0), 16'h0000);
    @(posedge ref_clk);
    area_sel_valid <= 1'b1;
    area_sel <= 1'b1;
    @(posedge ref_clk);
    area_sel_valid <= 1'b0;
    table_start <= 1'b1;
    @(posedge ref_clk);
    table_start <= 1'b0;
    present_mask <= 16'h0004;
    req(8'h71, 1'b1, 1'b0);
    drain();
    chk(c_addr, 4'h2);
    chk(c_area, 1'b0);
    chk(16'(n_word - w0), 16'h0008);
    req(8'h81, 1'b1, 1'b0);
    drain();
    chk(xfer_to_other_ff, 1'b1);
    chk(16'(n_word - w0), 16'h0008);
    @(posedge ref_clk);
    req_mark <= 1'b1;
    req(8'h72, 1'b1, 1'b0);
    drain();
    chk(16'(n_word - w0), 16'h0001);
  endtask
  // Display lags the step by one cycle, so look two edges after the enter
  task automatic key(input logic k, input logic [15:0] v, input logic [7:0] id,
      input logic [15:0] d);
    @(posedge ref_clk);
    man_enter <= 1'b1;
    man_keyed <= k;
    man_value <= v;
    @(posedge ref_clk);
    man_enter <= 1'b0;
    man_keyed <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(disp_id_ff, id);
    chk(disp_data_ff, d);
  endtask
  task automatic s_manual;
    int w1;
    @(posedge ref_clk);
    man_begin <= 1'b1;
    dsp <= 16'h0300;
    @(posedge ref_clk);
    man_begin <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(disp_id_ff, pod_pkg::STEP_DEV);
    key(1'b1, 16'h0009, pod_pkg::STEP_DEV, 16'h0000);
    key(1'b1, 16'h0000, pod_pkg::STEP_START, 16'h0008);
    key(1'b1, 16'h0000, pod_pkg::STEP_END, 16'h0300);
    key(1'b0, 16'h0000, pod_pkg::STEP_DUMP, 16'h0000);
    w1 = n_word;
    key(1'b1, 16'h0001, pod_pkg::STEP_DUMP, 16'h0000);
    @(posedge ref_clk);
    man_key <= 1'b1;
    @(posedge ref_clk);
    man_key <= 1'b0;
    drain();
    chk(16'(n_word - w1), 16'h0200);
    chk(16'(n_null - z0), 16'h0000);
    chk(disp_data_ff, 16'h0200);
    chk(xfer_addr_ff, 16'h01FF);
  endtask
  initial begin
    {reset_n, table_start, area_sel_valid, area_sel, req_valid, req_mark, slow} = '0;
    {area2_alloc, port_busy, man_begin, man_enter, man_keyed, man_key} = '0;
    {req_code, man_value, present_mask} = '0;
    dsp = 16'h0005;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    chk(dev_class_ff, pod_pkg::C_BAD);
    s_queue();
    s_fifo();
    s_module();
    s_manual();
    test_done();
  end
endmodule
